// [dpio_pkg.sv]
// Package with register map, reset values and pin masks of the dual port pin control block.
`default_nettype none

package dpio_pkg;

   // -------------------------------------------------------------------
   // Register byte offsets
   // -------------------------------------------------------------------
   localparam logic [5:0] ADDR_A_DATA = 6'h00;
   localparam logic [5:0] ADDR_A_DIR = 6'h04;
   localparam logic [5:0] ADDR_A_PULLUP = 6'h08;
   localparam logic [5:0] ADDR_A_DIGEN = 6'h0C;
   localparam logic [5:0] ADDR_B_DATA = 6'h10;
   localparam logic [5:0] ADDR_B_DIR = 6'h14;
   localparam logic [5:0] ADDR_B_PULLUP = 6'h18;
   localparam logic [5:0] ADDR_B_PULLDN = 6'h1C;
   localparam logic [5:0] ADDR_B_DIGEN = 6'h20;
   localparam logic [5:0] ADDR_IRQ_STATUS = 6'h24;
   localparam logic [5:0] ADDR_IRQ_CLEAR = 6'h28;
   localparam logic [5:0] ADDR_IRQ_ENABLE = 6'h2C;

   // -------------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------------
   localparam logic [7:0] RST_DATA = 8'h00;
   localparam logic [7:0] RST_DIR = 8'h00;
   localparam logic [7:0] RST_PULL = 8'h00;
   localparam logic [7:0] RST_DIGEN = 8'hFF;
   localparam logic [4:0] RST_IRQ = 5'h00;

   // -------------------------------------------------------------------
   // Pin capability masks
   // -------------------------------------------------------------------
   localparam logic [7:0] B_PULLDN_MASK = 8'h48;
   localparam logic [7:0] A_OPEN_DRAIN = 8'h20;
   localparam logic [7:0] B_OPEN_DRAIN = 8'h01;
   localparam logic [7:0] A_ANALOG_MASK = 8'h19;
   localparam logic [7:0] B_ANALOG_MASK = 8'hFE;

   // -------------------------------------------------------------------
   // Interrupt status bit positions
   // -------------------------------------------------------------------
   localparam int IRQ_WAKE = 0;
   localparam int IRQ_A0 = 1;
   localparam int IRQ_A4 = 2;
   localparam int IRQ_B0 = 3;
   localparam int IRQ_B5 = 4;

   // -------------------------------------------------------------------
   // Bus answers
   // -------------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

// [dpio_top.sv]
// Pin control logic for two 8-bit ports with an AXI4-Lite register slave.
//
// Behaviour
// - Each pin has data, direction, pull-high bits.
// - Only port B pins 3, 6 have pull-low.
// - Output driving low forces pull-up off.
// - Output driving high forces pull-low off.
// - Data read: stored bit when output, else pad.
// - Input mode: pull-up follows pull-high bit.
// - Output mode drives the stored data bit.
// - Input pull-high and pull-low act independently.
// - Pull-low pins in output: both pulls off.
// - Port A pin 5, B pin 0 open-drain.
// - Digital-input enable bit gates input path.
// - Power-save toggle on enabled pin requests wake-up.
// - External interrupt pins use digital input path.
// - Listed pins route to analog converter inputs.
// - Pad inputs pass a hysteresis stage first.
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
`default_nettype none

module dpio_top (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // AXI4-Lite write address and data
   input wire logic [31:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   // AXI4-Lite read
   input wire logic [31:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   // Port A pads
   input wire logic [7:0] pad_a_in,
   output logic [7:0] pad_a_out,
   output logic [7:0] pad_a_oe_out,
   output logic [7:0] pullup_a_out,
   output logic [7:0] analog_a_out,
   // Port B pads
   input wire logic [7:0] pad_b_in,
   output logic [7:0] pad_b_out,
   output logic [7:0] pad_b_oe_out,
   output logic [7:0] pullup_b_out,
   output logic [7:0] pulldown_b_out,
   output logic [7:0] analog_b_out,
   // System
   input wire logic power_save_in,
   output logic wake_out,
   output logic irq_out
);

   // -------------------------------------------------------------------
   // Register state
   // -------------------------------------------------------------------
   logic [7:0] a_data_q, a_dir_q, a_pullup_q, a_digen_q;
   logic [7:0] b_data_q, b_dir_q, b_pullup_q, b_pulldn_q, b_digen_q;
   logic [4:0] irq_status_q, irq_enable_q;

   // -------------------------------------------------------------------
   // Pad input synchronisers
   // -------------------------------------------------------------------
   // The pad cell supplies the Schmitt stage; only its clean output reaches here.
   logic [7:0] a_s1_q, a_s2_q, b_s1_q, b_s2_q;
   logic [7:0] a_prev_q, b_prev_q;
   logic [2:0] sync_fill_q;

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         a_s1_q <= 8'h00;
         a_s2_q <= 8'h00;
         b_s1_q <= 8'h00;
         b_s2_q <= 8'h00;
      end else begin
         a_s1_q <= pad_a_in;
         a_s2_q <= a_s1_q;
         b_s1_q <= pad_b_in;
         b_s2_q <= b_s1_q;
      end
   end

   // A disabled digital input reads as zero, so an analog pin never toggles the logic.
   wire [7:0] a_gated = a_s2_q & a_digen_q;
   wire [7:0] b_gated = b_s2_q & b_digen_q;
   // Edges are taken on the raw level and then masked, so writing an enable bit on a high pad
   // is never seen as a toggle. Nothing counts until the chain holds settled pad levels, which
   // keeps a pad that idles high from raising a false event right after reset.
   wire edge_ready = sync_fill_q[2];
   wire [7:0] a_toggle = (a_s2_q ^ a_prev_q) & a_digen_q & {8{edge_ready}};
   wire [7:0] b_toggle = (b_s2_q ^ b_prev_q) & b_digen_q & {8{edge_ready}};

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         a_prev_q <= 8'h00;
         b_prev_q <= 8'h00;
         sync_fill_q <= 3'h0;
      end else begin
         a_prev_q <= a_s2_q;
         b_prev_q <= b_s2_q;
         sync_fill_q <= {sync_fill_q[1:0], 1'b1};
      end
   end

   // -------------------------------------------------------------------
   // Events and interrupt
   // -------------------------------------------------------------------
   // Wake-up does not look at the pin direction; software keeps wake pins in input mode.
   wire wake_event = power_save_in & ((|a_toggle) | (|b_toggle));
   wire [4:0] irq_event = {b_toggle[5], b_toggle[0], a_toggle[4], a_toggle[0], wake_event};

   // -------------------------------------------------------------------
   // AXI4-Lite write channel
   // -------------------------------------------------------------------
   // Address and data are held separately, so the master may offer them in either order;
   // the register changes only once both are held and no answer is still pending.
   logic aw_held_q, w_held_q;
   logic [5:0] aw_addr_q;
   logic [7:0] w_data_q;
   logic w_strb_q;

   wire aw_take = s_axi_awvalid_in & s_axi_awready_out;
   wire w_take = s_axi_wvalid_in & s_axi_wready_out;
   wire wr_fire = aw_held_q & w_held_q & ~s_axi_bvalid_out;
   wire wr_en = wr_fire & w_strb_q;
   wire wa_a_data = (aw_addr_q == dpio_pkg::ADDR_A_DATA);
   wire wa_a_dir = (aw_addr_q == dpio_pkg::ADDR_A_DIR);
   wire wa_a_pu = (aw_addr_q == dpio_pkg::ADDR_A_PULLUP);
   wire wa_a_den = (aw_addr_q == dpio_pkg::ADDR_A_DIGEN);
   wire wa_b_data = (aw_addr_q == dpio_pkg::ADDR_B_DATA);
   wire wa_b_dir = (aw_addr_q == dpio_pkg::ADDR_B_DIR);
   wire wa_b_pu = (aw_addr_q == dpio_pkg::ADDR_B_PULLUP);
   wire wa_b_pd = (aw_addr_q == dpio_pkg::ADDR_B_PULLDN);
   wire wa_b_den = (aw_addr_q == dpio_pkg::ADDR_B_DIGEN);
   wire wa_stat = (aw_addr_q == dpio_pkg::ADDR_IRQ_STATUS);
   wire wa_clr = (aw_addr_q == dpio_pkg::ADDR_IRQ_CLEAR);
   wire wa_en = (aw_addr_q == dpio_pkg::ADDR_IRQ_ENABLE);
   wire wa_ok = wa_a_data | wa_a_dir | wa_a_pu | wa_a_den | wa_b_data | wa_b_dir | wa_b_pu | wa_b_pd
      | wa_b_den | wa_stat | wa_clr | wa_en;
   wire [4:0] irq_clear = (wr_en & wa_clr) ? w_data_q[4:0] : 5'h00;

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         aw_addr_q <= 6'h00;
         w_data_q <= 8'h00;
         w_strb_q <= 1'b0;
      end else begin
         if (aw_take) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr_in[5:0];
         end else if (wr_fire) begin
            aw_held_q <= 1'b0;
         end
         if (w_take) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata_in[7:0];
            w_strb_q <= s_axi_wstrb_in[0];
         end else if (wr_fire) begin
            w_held_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         s_axi_awready_out <= 1'b0;
         s_axi_wready_out <= 1'b0;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= dpio_pkg::RESP_OKAY;
      end else begin
         // Ready drops for the cycle after a take, so one offered item is never taken twice.
         s_axi_awready_out <= ~aw_held_q & ~aw_take & ~s_axi_bvalid_out & ~wr_fire;
         s_axi_wready_out <= ~w_held_q & ~w_take & ~s_axi_bvalid_out & ~wr_fire;
         if (wr_fire) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= wa_ok ? dpio_pkg::RESP_OKAY : dpio_pkg::RESP_SLVERR;
         end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------
   // Registers written by software
   // -------------------------------------------------------------------
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         a_data_q <= dpio_pkg::RST_DATA;
         a_dir_q <= dpio_pkg::RST_DIR;
         a_pullup_q <= dpio_pkg::RST_PULL;
         a_digen_q <= dpio_pkg::RST_DIGEN;
         b_data_q <= dpio_pkg::RST_DATA;
         b_dir_q <= dpio_pkg::RST_DIR;
         b_pullup_q <= dpio_pkg::RST_PULL;
         b_pulldn_q <= dpio_pkg::RST_PULL;
         b_digen_q <= dpio_pkg::RST_DIGEN;
         irq_enable_q <= dpio_pkg::RST_IRQ;
      end else if (wr_en) begin
         if (wa_a_data) a_data_q <= w_data_q;
         if (wa_a_dir) a_dir_q <= w_data_q;
         if (wa_a_pu) a_pullup_q <= w_data_q;
         if (wa_a_den) a_digen_q <= w_data_q;
         if (wa_b_data) b_data_q <= w_data_q;
         if (wa_b_dir) b_dir_q <= w_data_q;
         if (wa_b_pu) b_pullup_q <= w_data_q;
         if (wa_b_pd) b_pulldn_q <= w_data_q & dpio_pkg::B_PULLDN_MASK;
         if (wa_b_den) b_digen_q <= w_data_q;
         if (wa_en) irq_enable_q <= w_data_q[4:0];
      end
   end

   // A new event wins over a clear that lands in the same cycle.
   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         irq_status_q <= dpio_pkg::RST_IRQ;
      end else begin
         irq_status_q <= (irq_status_q & ~irq_clear) | irq_event;
      end
   end

   // -------------------------------------------------------------------
   // AXI4-Lite read channel
   // -------------------------------------------------------------------
   // Unmapped offsets answer with an error and read as zero. The clear register has no
   // storage behind it and always reads as zero.
   wire [5:0] ra = s_axi_araddr_in[5:0];
   wire ar_take = s_axi_arvalid_in & s_axi_arready_out;
   wire [7:0] a_read = (a_dir_q & a_data_q) | (~a_dir_q & a_gated);
   wire [7:0] b_read = (b_dir_q & b_data_q) | (~b_dir_q & b_gated);
   logic [7:0] rd_val;
   logic rd_ok;

   always_comb begin
      rd_val = 8'h00;
      rd_ok = 1'b1;
      if (ra == dpio_pkg::ADDR_A_DATA) begin
         rd_val = a_read;
      end else if (ra == dpio_pkg::ADDR_A_DIR) begin
         rd_val = a_dir_q;
      end else if (ra == dpio_pkg::ADDR_A_PULLUP) begin
         rd_val = a_pullup_q;
      end else if (ra == dpio_pkg::ADDR_A_DIGEN) begin
         rd_val = a_digen_q;
      end else if (ra == dpio_pkg::ADDR_B_DATA) begin
         rd_val = b_read;
      end else if (ra == dpio_pkg::ADDR_B_DIR) begin
         rd_val = b_dir_q;
      end else if (ra == dpio_pkg::ADDR_B_PULLUP) begin
         rd_val = b_pullup_q;
      end else if (ra == dpio_pkg::ADDR_B_PULLDN) begin
         rd_val = b_pulldn_q;
      end else if (ra == dpio_pkg::ADDR_B_DIGEN) begin
         rd_val = b_digen_q;
      end else if (ra == dpio_pkg::ADDR_IRQ_STATUS) begin
         rd_val = {3'h0, irq_status_q};
      end else if (ra == dpio_pkg::ADDR_IRQ_CLEAR) begin
         rd_val = 8'h00;
      end else if (ra == dpio_pkg::ADDR_IRQ_ENABLE) begin
         rd_val = {3'h0, irq_enable_q};
      end else begin
         rd_ok = 1'b0;
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= 32'h0000_0000;
         s_axi_rresp_out <= dpio_pkg::RESP_OKAY;
      end else begin
         s_axi_arready_out <= ~s_axi_rvalid_out & ~ar_take;
         if (ar_take) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out <= {24'h00_0000, rd_val};
            s_axi_rresp_out <= rd_ok ? dpio_pkg::RESP_OKAY : dpio_pkg::RESP_SLVERR;
         end else if (s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------
   // Pad drive and pull control
   // -------------------------------------------------------------------
   wire [7:0] a_drv_low = a_dir_q & ~a_data_q;
   wire [7:0] b_drv_low = b_dir_q & ~b_data_q;
   // Open-drain pins have no high-side driver, so a high only releases the line.
   wire [7:0] a_oe = a_dir_q & ~(dpio_pkg::A_OPEN_DRAIN & a_data_q);
   wire [7:0] b_oe = b_dir_q & ~(dpio_pkg::B_OPEN_DRAIN & b_data_q);
   wire [7:0] a_pu = a_pullup_q & ~a_drv_low;
   // Pull-low pins drop both pulls in output mode; the others keep pull-up while high.
   wire [7:0] b_pu = b_pullup_q & ~b_drv_low & ~(dpio_pkg::B_PULLDN_MASK & b_dir_q);
   wire [7:0] b_pd = b_pulldn_q & dpio_pkg::B_PULLDN_MASK & ~b_dir_q;

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         pad_a_out <= 8'h00;
         pad_a_oe_out <= 8'h00;
         pullup_a_out <= 8'h00;
         analog_a_out <= 8'h00;
         pad_b_out <= 8'h00;
         pad_b_oe_out <= 8'h00;
         pullup_b_out <= 8'h00;
         pulldown_b_out <= 8'h00;
         analog_b_out <= 8'h00;
         wake_out <= 1'b0;
         irq_out <= 1'b0;
      end else begin
         pad_a_out <= a_data_q & ~dpio_pkg::A_OPEN_DRAIN;
         pad_a_oe_out <= a_oe;
         pullup_a_out <= a_pu;
         // The analog route opens only on capable pins whose digital input is switched off.
         analog_a_out <= ~a_digen_q & dpio_pkg::A_ANALOG_MASK;
         pad_b_out <= b_data_q & ~dpio_pkg::B_OPEN_DRAIN;
         pad_b_oe_out <= b_oe;
         pullup_b_out <= b_pu;
         pulldown_b_out <= b_pd;
         analog_b_out <= ~b_digen_q & dpio_pkg::B_ANALOG_MASK;
         wake_out <= wake_event;
         // Because every output is registered, the interrupt level lags its status bit by one clock.
         irq_out <= |(irq_status_q & irq_enable_q);
      end
   end

endmodule

`default_nettype wire

// [dpio_assertions.sv]
// Checker of the pin control outputs of the dual port block.
`default_nettype none
module dpio_chk (
   // Clock, reset and read handshake
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic s_axi_arvalid_in,
   input wire logic s_axi_arready_out,
   input wire logic s_axi_rvalid_out,
   // Pins
   input wire logic [7:0] pad_a_out,
   input wire logic [7:0] pad_a_oe_out,
   input wire logic [7:0] pullup_a_out,
   input wire logic [7:0] analog_a_out,
   input wire logic [7:0] pad_b_out,
   input wire logic [7:0] pad_b_oe_out,
   input wire logic [7:0] pullup_b_out,
   input wire logic [7:0] pulldown_b_out,
   input wire logic [7:0] analog_b_out,
   input wire logic power_save_in,
   input wire logic wake_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock_in); endclocking
   default disable iff (rst_in);
   sequence s_ar_take;
      s_axi_arvalid_in && s_axi_arready_out;
   endsequence
   // Three awake samples cover the whole path from pad to wake output.
   sequence s_awake;
      !power_save_in [*3];
   endsequence
   chk_read_answer: assert property (s_ar_take |=> s_axi_rvalid_out)
      else $error("read answer missing");
   chk_open_drain: assert property (!pad_a_out[5] && !pad_b_out[0])
      else $error("open drain pin driven high");
   chk_pulldn_pins: assert property ((pulldown_b_out & 8'hB7) == 8'h00)
      else $error("pull down on wrong pin");
   chk_low_pullup_off: assert property (((pad_a_oe_out & ~pad_a_out & pullup_a_out) |
      (pad_b_oe_out & ~pad_b_out & pullup_b_out)) == 8'h00) else $error("pull up on low output");
   chk_high_pulldn_off: assert property ((pad_b_oe_out & pad_b_out & pulldown_b_out) == 8'h00)
      else $error("pull down on high output");
   chk_output_pulls_off: assert property ((pad_b_oe_out & 8'h48 & (pullup_b_out | pulldown_b_out)) == 8'h00)
      else $error("pull on output pin");
   chk_reset_inputs: assert property ($fell(rst_in) |-> (pad_a_oe_out | pad_b_oe_out) == 8'h00)
      else $error("pin driven after reset");
   chk_analog_pins: assert property ((analog_a_out & 8'hE6) == 8'h00 && !analog_b_out[0])
      else $error("analog route on wrong pin");
   chk_wake_gate: assert property (s_awake |-> !wake_out)
      else $error("wake outside power save");
endmodule
bind dpio_top dpio_chk u_chk (.clock_in, .rst_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out,
   .pad_a_out, .pad_a_oe_out, .pullup_a_out, .analog_a_out, .pad_b_out, .pad_b_oe_out, .pullup_b_out,
   .pulldown_b_out, .analog_b_out, .power_save_in, .wake_out);
`default_nettype wire

// [dpio_board.sv]
// Board model that sets the level seen at one port's pads.
`default_nettype none
module dpio_board (
   // Design side
   input wire logic clock_in,
   input wire logic [7:0] drv_in,
   input wire logic [7:0] oe_in,
   input wire logic [7:0] up_in,
   input wire logic [7:0] dn_in,
   // Bench side
   input wire logic [7:0] ext_in,
   input wire logic [7:0] ext_en_in,
   output logic [7:0] lvl_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // A floating line moves every cycle, so a kept old value can never pass.
   logic [7:0] float_q = 8'h55;
   always_ff @(posedge clock_in) float_q <= ~float_q;
   assign lvl_out = (oe_in & drv_in) | (~oe_in & ext_en_in & ext_in) |
      (~oe_in & ~ext_en_in & (up_in | (~dn_in & float_q)));
endmodule
`default_nettype wire

// [dpio_tb.sv]
// Self-checking bench of the dual port pin control block.
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_in = 1'b0;
   logic rst_in = 1'b1;
   logic [31:0] awa = '0, wda = '0, ara = '0, rd, got;
   logic awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0, ps = 1'b0;
   logic awr, wr_r, bv, arr, rv, wake, irq;
   logic [1:0] br, rr, resp;
   logic [7:0] ext_a = 8'h00, ext_b = 8'h00, pa, pb, oa, ob, ua, ub, db, ana, anb, lva, lvb;
   logic [3:0] wst = 4'hF;
   int fails = 0, cmp_count = 0, wakes = 0;
   int mdl [int];
   always #5 clock_in = ~clock_in;
   always @(posedge clock_in) if (wake === 1'b1) wakes++;
   dpio_top DUT (.clock_in, .rst_in, .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
      .s_axi_wdata_in(wda), .s_axi_wstrb_in(wst), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_r),
      .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(brd), .s_axi_araddr_in(ara),
      .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rd), .s_axi_rresp_out(rr),
      .s_axi_rvalid_out(rv), .s_axi_rready_in(rrd), .pad_a_in(lva), .pad_a_out(pa), .pad_a_oe_out(oa),
      .pullup_a_out(ua), .analog_a_out(ana), .pad_b_in(lvb), .pad_b_out(pb), .pad_b_oe_out(ob),
      .pullup_b_out(ub), .pulldown_b_out(db), .analog_b_out(anb), .power_save_in(ps), .wake_out(wake),
      .irq_out(irq));
   dpio_board brd_a (.clock_in, .drv_in(pa), .oe_in(oa), .up_in(ua), .dn_in(8'h00), .ext_in(ext_a),
      .ext_en_in(8'hFF), .lvl_out(lva));
   dpio_board brd_b (.clock_in, .drv_in(pb), .oe_in(ob), .up_in(ub), .dn_in(db), .ext_in(ext_b),
      .ext_en_in(8'hFF), .lvl_out(lvb));
   // ------------------------------------------------------------
   // Bus and compare tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock_in);
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      bit done = 1'b0;
      @(posedge clock_in);
      awa <= {26'h0, a};
      wda <= {24'h0, d};
      awv <= 1'b1;
      wv <= 1'b1;
      brd <= 1'b1;
      // Data, clear and unmapped registers do not read back what was written; a cleared low strobe writes nothing.
      if (wst[0] && a != 6'h00 && a != 6'h10 && a != 6'h28 && a != 6'h30)
         mdl[a] = d & ((a == 6'h1C) ? 8'h48 : 8'hFF);
      while (!done) begin
         @(posedge clock_in);
         if (awv && awr) awv <= 1'b0;
         if (wv && wr_r) wv <= 1'b0;
         if (bv === 1'b1) begin
            resp = br;
            brd <= 1'b0;
            done = 1'b1;
         end
      end
   endtask
   task automatic rg(input logic [5:0] a);
      bit done = 1'b0;
      @(posedge clock_in);
      ara <= {26'h0, a};
      arv <= 1'b1;
      rrd <= 1'b1;
      while (!done) begin
         @(posedge clock_in);
         if (arv && arr) arv <= 1'b0;
         if (rv === 1'b1) begin
            got = rd;
            resp = rr;
            rrd <= 1'b0;
            done = 1'b1;
         end
      end
   endtask
   task automatic check_regs();
      foreach (mdl[k]) begin
         rg(6'(k));
         chk(got, 32'(mdl[k]));
      end
   endtask
   task automatic port_test(input bit b);
      logic [7:0] d, r, u, p, g, e, od, pdm, x;
      logic [5:0] base;
      {d, r, u, p} = $urandom();
      {g, e} = 16'($urandom());
      od = b ? 8'h01 : 8'h20;
      pdm = b ? 8'h48 : 8'h00;
      base = b ? 6'h10 : 6'h00;
      if (b) ext_b <= e;
      else ext_a <= e;
      wr(base, d);
      wr(base + 6'h04, r);
      wr(base + 6'h08, u);
      wr(b ? 6'h20 : 6'h0C, g);
      wr(6'h1C, p);
      tick(4);
      x = r & ~(od & d);
      chk(b ? ob : oa, x);
      chk((b ? pb : pa) & x, d & ~od & x);
      chk(b ? ub : ua, u & ~(r & ~d) & ~(r & pdm));
      chk(db, p & 8'h48 & ~(b ? r : mdl[6'h14]));
      chk(b ? anb : ana, ~g & (b ? 8'hFE : 8'h19));
      rg(base);
      chk(got, (r & d) | (~r & e & g));
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      #200us;
      fails++;
      print_verdict();
   end
   initial begin
      void'($urandom(86843));
      mdl = '{6'h04: 0, 6'h08: 0, 6'h0C: 8'hFF, 6'h14: 0, 6'h18: 0, 6'h1C: 0, 6'h20: 8'hFF, 6'h2C: 0};
      tick(5);
      rst_in <= 1'b0;
      tick(1);
      chk({oa, ob}, 32'h0);
      check_regs();
      rg(6'h30);
      chk(resp, dpio_pkg::RESP_SLVERR);
      wr(6'h30, 8'hFF);
      chk(resp, dpio_pkg::RESP_SLVERR);
      wst <= 4'h0;
      wr(6'h08, 8'hFF);
      chk(resp, dpio_pkg::RESP_OKAY);
      wst <= 4'hF;
      check_regs();
      $display("reset test done");
      for (int i = 0; i < 12; i++) port_test(i[0]);
      check_regs();
      $display("pin test done");
      ext_a <= 8'h00;
      ext_b <= 8'h00;
      wr(6'h04, 8'h00);
      wr(6'h14, 8'h00);
      wr(6'h0C, 8'hFF);
      wr(6'h20, 8'hFF);
      wr(6'h28, 8'h1F);
      wr(6'h2C, 8'h1F);
      rg(6'h24);
      chk(got, 32'h0);
      ext_a <= 8'h11;
      tick(6);
      rg(6'h24);
      chk(got, 32'h6);
      chk(irq, 32'h1);
      wr(6'h2C, 8'h00);
      tick(2);
      chk(irq, 32'h0);
      ext_a <= 8'h00;
      wr(6'h2C, 8'h1F);
      tick(6);
      wr(6'h28, 8'h06);
      tick(2);
      chk(irq, 32'h0);
      rg(6'h28);
      chk(got, 32'h0);
      wr(6'h0C, 8'hFE);
      ext_a <= 8'h01;
      tick(6);
      rg(6'h24);
      chk(got, 32'h0);
      chk(wakes, 32'h0);
      ps <= 1'b1;
      ext_b <= 8'h21;
      tick(6);
      rg(6'h24);
      chk(got, 32'h19);
      chk(wakes, 32'h1);
      $display("event test done");
      print_verdict();
   end
endmodule
`default_nettype wire
